/* File: iap_pkg.sv */
package iap_pkg;

    localparam int ADDR_W_DEF = 12;
    localparam int PAIRS_DEF = 3;
    localparam int BYTE_W = 8;
    localparam int OP_COUNT = 5;

    // Pair n: low byte at PTR_BASE + n*PTR_STRIDE, high byte HIGH_OFS above.
    localparam logic [7:0] PTR_BASE = 8'h00;
    localparam logic [7:0] PTR_STRIDE = 8'h08;
    localparam logic [7:0] HIGH_OFS = 8'h04;
    localparam logic [7:0] WREG_ADDR = 8'h30;
    localparam logic [7:0] BANK_ADDR = 8'h34;
    // Operand k of pair n sits at OPND_BASE + n*OPND_STRIDE + k*OP_STEP.
    localparam logic [7:0] OPND_BASE = 8'h40;
    localparam logic [7:0] OPND_STRIDE = 8'h20;
    localparam logic [7:0] OP_STEP = 8'h04;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        OP_PLAIN,
        OP_POST_DECREMENT_OPERAND,
        OP_POST_INCREMENT_OPERAND,
        OP_PRE_INCREMENT_OPERAND,
        OP_OFFSET
    } iap_op_type;

    typedef struct packed {
        logic is_ptr;
        logic is_high;
        logic is_opnd;
        logic is_wreg;
        logic is_bank;
        logic [1:0] pair;
        iap_op_type op;
    } iap_dec_type;

endpackage : iap_pkg

/* File: iap_pointers.sv */
// Notes on behaviour
// - Three pairs, two bytes, twelve bits each.
// - Twelve-bit pointer addresses whole data memory linearly.
// - Plain operand accesses memory at pair's pointer.
// - Plain operand leaves the pointer unchanged.
// - Bank select never affects indirect addresses.
// - Four more operands access memory plus action.
// - Post-decrement: access, then pointer minus one.
// - Post-increment: access, then pointer plus one.
// - Pre-increment: pointer plus one, then access.
// - Offset operand adds signed working value.
// - Offset leaves working register and pointer unchanged.
module iap_pointers
    import iap_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int PAIRS = PAIRS_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int HI_W = ADDR_W - BYTE_W;

    generate
        if (ADDR_W < 9 || ADDR_W > 16 || PAIRS < 1 || PAIRS > 4) begin : g_chk
            $error("iap_pointers: unsupported ADDR_W or PAIRS");
        end
    endgenerate

    logic [ADDR_W-1:0] ptr_q [PAIRS];
    logic [ADDR_W-1:0] ptr_d [PAIRS];
    logic [7:0] wreg_q;
    logic [7:0] wreg_d;
    logic [7:0] bank_q;
    logic [7:0] bank_d;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    logic wait_q;
    logic wait_d;
    logic [7:0] mem [MEM_DEPTH];

    iap_dec_type dec;
    logic req;
    logic done;
    logic wr_en;
    logic mem_we;
    logic [ADDR_W-1:0] ptr_sel;
    logic [ADDR_W-1:0] woff;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] new_ptr;

    // Address decode of the register window.
    always_comb begin
        dec = '0;
        for (int p = 0; p < PAIRS; p++) begin
            if (avs_address == 8'(PTR_BASE + p * PTR_STRIDE)) begin
                dec.is_ptr = 1'b1;
                dec.pair = 2'(p);
            end
            if (avs_address == 8'(PTR_BASE + p * PTR_STRIDE + HIGH_OFS)) begin
                dec.is_ptr = 1'b1;
                dec.is_high = 1'b1;
                dec.pair = 2'(p);
            end
            for (int k = 0; k < OP_COUNT; k++) begin
                if (avs_address ==
                    8'(OPND_BASE + p * OPND_STRIDE + k * OP_STEP)) begin
                    dec.is_opnd = 1'b1;
                    dec.pair = 2'(p);
                    dec.op = iap_op_type'(k);
                end
            end
        end
        dec.is_wreg = (avs_address == WREG_ADDR);
        dec.is_bank = (avs_address == BANK_ADDR);
    end

    // Effective address and pointer action.  The bank register is never
    // consulted here, so banking cannot disturb an indirect target.
    always_comb begin
        ptr_sel = ptr_q[dec.pair];
        woff = {{HI_W{wreg_q[7]}}, wreg_q};
        eff_addr = ptr_sel;
        new_ptr = ptr_sel;
        case (dec.op)
            OP_PLAIN: begin
                eff_addr = ptr_sel;
            end
            OP_POST_DECREMENT_OPERAND: begin
                new_ptr = ptr_sel - 1'b1;
            end
            OP_POST_INCREMENT_OPERAND: begin
                new_ptr = ptr_sel + 1'b1;
            end
            OP_PRE_INCREMENT_OPERAND: begin
                new_ptr = ptr_sel + 1'b1;
                eff_addr = new_ptr;
            end
            OP_OFFSET: begin
                eff_addr = ptr_sel + woff;
            end
            default: begin
                eff_addr = ptr_sel;
            end
        endcase
    end

    // Avalon handshake: waitrequest drops for exactly one cycle per request,
    // and writes and pointer actions take effect at the edge where it is seen low; read data is loaded one edge earlier.
    always_comb begin
        req = avs_read | avs_write;
        wait_d = !(req && wait_q);
        done = req && !wait_q;
        wr_en = done && avs_write && avs_byteenable[0];
        mem_we = wr_en && dec.is_opnd;
    end

    always_comb begin
        readdata_d = readdata_q;
        // Only a read refreshes the data register, so it holds across writes.
        if (avs_read && wait_q) begin
            readdata_d = READ_ZERO;
            if (dec.is_ptr && dec.is_high) begin
                readdata_d[7:0] = {{(BYTE_W - HI_W){1'b0}},
                                   ptr_sel[ADDR_W-1:BYTE_W]};
            end else if (dec.is_ptr) begin
                readdata_d[7:0] = ptr_sel[BYTE_W-1:0];
            end else if (dec.is_opnd) begin
                readdata_d[7:0] = mem[eff_addr];
            end else if (dec.is_wreg) begin
                readdata_d[7:0] = wreg_q;
            end else if (dec.is_bank) begin
                readdata_d[7:0] = bank_q;
            end
        end
    end

    always_comb begin
        for (int p = 0; p < PAIRS; p++) begin
            ptr_d[p] = ptr_q[p];
        end
        wreg_d = wreg_q;
        bank_d = bank_q;
        // Both reads and writes of an operand apply its pointer action.
        if (done && dec.is_opnd) begin
            ptr_d[dec.pair] = new_ptr;
        end
        if (wr_en && dec.is_ptr && dec.is_high) begin
            ptr_d[dec.pair][ADDR_W-1:BYTE_W] =
                avs_writedata[HI_W-1:0];
        end else if (wr_en && dec.is_ptr) begin
            ptr_d[dec.pair][BYTE_W-1:0] = avs_writedata[7:0];
        end
        if (wr_en && dec.is_wreg) begin
            wreg_d = avs_writedata[7:0];
        end
        if (wr_en && dec.is_bank) begin
            bank_d = avs_writedata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < PAIRS; p++) begin
                ptr_q[p] <= '0;
            end
            wreg_q <= BYTE_RESET;
            bank_q <= BYTE_RESET;
            readdata_q <= READ_ZERO;
            wait_q <= 1'b1;
        end else begin
            for (int p = 0; p < PAIRS; p++) begin
                ptr_q[p] <= ptr_d[p];
            end
            wreg_q <= wreg_d;
            bank_q <= bank_d;
            readdata_q <= readdata_d;
            wait_q <= wait_d;
        end
    end

    // Data memory has no reset; software must initialise what it reads.
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[eff_addr] <= avs_writedata[7:0];
        end
    end

    assign avs_readdata = readdata_q;
    assign avs_waitrequest = wait_q;

endmodule : iap_pointers

/* File: iap_chk_assertions.sv */
module iap_chk
    import iap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_wait_one_cycle: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
    a_req_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    a_idle_wait: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    a_answer_cause: assert property (
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without cause");
    a_read_seq: assert property (
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered on second edge");
    a_data_hold: assert property (
        !avs_read |=> $stable(avs_readdata)) else $error("readdata moved");
    a_upper_zero: assert property (
        avs_readdata[31:8] == 24'h00_0000) else $error("upper bits set");
    a_high_nibble: assert property (
        avs_read && !avs_waitrequest && avs_address < 8'h18
        && avs_address[2:0] == 3'h4 |-> avs_readdata[7:4] == 4'h0)
        else $error("unused high bits set");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h3C
        |-> avs_readdata == READ_ZERO) else $error("unmapped read");
endmodule : iap_chk
bind iap_pointers iap_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

/* File: iap_master.sv */
module iap_master (
    input wire logic ref_clk,
    input wire logic avs_waitrequest,
    output logic [7:0] avs_address = 8'h00,
    output logic avs_read = 1'h0,
    output logic avs_write = 1'h0,
    output logic [31:0] avs_writedata = 32'h0000_0000,
    output logic [3:0] avs_byteenable = 4'h1
);
    timeunit 1ns;
    timeprecision 1ns;
    task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {24'h00_0000, d};
        do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : xfer
endmodule : iap_master

/* File: iap_pointers_tb.sv */
module iap_pointers_tb;
    import iap_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] adr;
    logic rd, wr, wt;
    logic [31:0] wd, rdat;
    logic [3:0] be;
    logic [31:0] q[$];
    logic [11:0] p[3];
    logic [7:0] w;
    logic [7:0] mem[4096];
    int err_count = 0;
    int checks = 0;
    iap_pointers uut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt));
    iap_master m (.ref_clk(ref_clk), .avs_waitrequest(wt),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be));
    initial forever #10 ref_clk = ~ref_clk;
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    always @(posedge ref_clk) begin
        if (rd && wt === 1'h0) chk("readdata", rdat, q.pop_front());
    end
    task rreg(input logic [7:0] a, input logic [7:0] e);
        q.push_back({24'h00_0000, e});
        m.xfer(a, 1'h0, 8'h00);
    endtask : rreg
    // The model applies the pointer action before the bus transfer (read or write) is issued.
    task op(input int n, input int k, input logic wrt, input logic [7:0] d);
        logic [11:0] a;
        if (k == 3) p[n] = p[n] + 12'h001;
        a = (k == 4) ? p[n] + {{4{w[7]}}, w} : p[n];
        if (k == 1) p[n] = p[n] - 12'h001;
        if (k == 2) p[n] = p[n] + 12'h001;
        // Never-written memory reads X on both sides; write it instead.
        if (!wrt && $isunknown(mem[a])) wrt = 1'h1;
        if (wrt) mem[a] = d;
        else q.push_back({24'h00_0000, mem[a]});
        m.xfer(8'(OPND_BASE + n * OPND_STRIDE + k * OP_STEP), wrt, d);
    endtask : op
    task set_ptr(input int n, input logic [11:0] v);
        p[n] = v;
        m.xfer(8'(PTR_BASE + n * PTR_STRIDE), 1'h1, v[7:0]);
        m.xfer(8'(PTR_BASE + n * PTR_STRIDE + HIGH_OFS), 1'h1, {4'hF, v[11:8]});
    endtask : set_ptr
    task check_ptrs;
        for (int n = 0; n < 3; n++) begin
            rreg(8'(PTR_BASE + n * PTR_STRIDE), p[n][7:0]);
            rreg(8'(PTR_BASE + n * PTR_STRIDE + HIGH_OFS), {4'h0, p[n][11:8]});
        end
    endtask : check_ptrs
    task close_out;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        #200000;
        err_count++;
        close_out();
    end
    initial begin
        void'($urandom(79));
        w = 8'h00;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'h1;
        for (int n = 0; n < 3; n++) set_ptr(n, 12'($urandom));
        check_ptrs();
        set_ptr(0, 12'hFFF);
        op(0, 2, 1'h1, 8'h5A);
        op(0, 2, 1'h1, 8'hA5);
        op(0, 1, 1'h0, 8'h00);
        op(0, 0, 1'h0, 8'h00);
        for (int i = 0; i < 240; i++) begin
            if (i % 20 == 0) begin
                w = 8'($urandom);
                m.xfer(WREG_ADDR, 1'h1, w);
                m.xfer(BANK_ADDR, 1'h1, 8'($urandom));
            end
            op($urandom_range(2), $urandom_range(4), 1'($urandom), 8'($urandom));
        end
        check_ptrs();
        rreg(WREG_ADDR, w);
        m.xfer(8'h3C, 1'h1, 8'hFF);
        rreg(8'h3C, 8'h00);
        close_out();
    end
endmodule : iap_pointers_tb
